// File: src/mcr_pkg.sv
// Shared constants of the memory copy relay: register map, fields, reset values
package mcr_pkg;

   // ----------------------------------------
   // Bus and field widths
   // ----------------------------------------
   localparam int unsigned DATA_W = 32;
   localparam int unsigned OFF_W  = 12;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned SIZE_W = 2;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] OFF_HOLD    = 12'h000;
   localparam logic [11:0] OFF_SIZE    = 12'h004;
   localparam logic [11:0] OFF_IER     = 12'h008;
   localparam logic [11:0] OFF_IDR     = 12'h00C;
   localparam logic [11:0] OFF_IMR     = 12'h010;
   localparam logic [11:0] OFF_ISR     = 12'h014;
   localparam logic [11:0] OFF_RSV_LO  = 12'h018;
   localparam logic [11:0] OFF_RSV_HI  = 12'h0FC;
   localparam logic [11:0] OFF_CHAN_LO = 12'h100;
   localparam logic [11:0] OFF_CHAN_HI = 12'h124;
   localparam logic [11:0] OFF_EVT     = 12'h128;
   localparam logic [11:0] OFF_EVT_CLR = 12'h12C;

   // ----------------------------------------
   // Element size codes and lane masks
   // ----------------------------------------
   localparam logic [1:0]  SIZE_BYTE = 2'h0;
   localparam logic [1:0]  SIZE_HALF = 2'h1;
   localparam logic [1:0]  SIZE_WORD = 2'h2;
   localparam logic [31:0] LANE_BYTE = 32'h0000_00FF;
   localparam logic [31:0] LANE_HALF = 32'h0000_FFFF;
   localparam logic [31:0] LANE_WORD = 32'hFFFF_FFFF;

   // ----------------------------------------
   // Flag positions and reset values
   // ----------------------------------------
   localparam int unsigned BIT_END  = 0;
   localparam int unsigned BIT_FULL = 1;
   localparam logic [31:0] HOLD_RST = 32'h0000_0000;
   localparam logic [1:0]  SIZE_RST = SIZE_WORD;
   localparam logic [1:0]  MASK_RST = 2'h0;
   localparam logic [1:0]  EVT_RST  = 2'h0;

endpackage : mcr_pkg

// File: src/mcr_irq_if.sv
// Interface between the register front end and the interrupt unit
`timescale 1ns/1ps
interface mcr_irq_if;
   logic                      set_wr;
   logic                      clr_wr;
   logic                      evt_clr_wr;
   logic [mcr_pkg::FLAG_N-1:0] wbits;
   logic [mcr_pkg::FLAG_N-1:0] flags;
   logic [mcr_pkg::FLAG_N-1:0] mask;
   logic [mcr_pkg::FLAG_N-1:0] evt;
   logic                      irq;

   modport regs (output set_wr, output clr_wr, output evt_clr_wr, output wbits, output flags,
                 input mask, input evt, input irq);
   modport unit (input set_wr, input clr_wr, input evt_clr_wr, input wbits, input flags,
                 output mask, output evt, output irq);
endinterface : mcr_irq_if

// File: src/mcr_irq_unit.sv
// Interrupt mask, sticky event latches and the interrupt line
`timescale 1ns/1ps
module mcr_irq_unit #(
   parameter int unsigned FLAG_N = mcr_pkg::FLAG_N
) (
   input wire logic pclk,
   input wire logic presetn,
   mcr_irq_if.unit  bus
);
   import mcr_pkg::*;

   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   if (FLAG_N != mcr_pkg::FLAG_N) begin : g_bad_flag_n
      $error("FLAG_N must match the interface width");
   end

   logic [FLAG_N-1:0] mask_q;
   logic [FLAG_N-1:0] mask_d;
   logic [FLAG_N-1:0] prev_q;
   logic [FLAG_N-1:0] evt_q;
   logic [FLAG_N-1:0] rise;
   logic [FLAG_N-1:0] set_bits;
   logic [FLAG_N-1:0] clr_bits;

   // Ones set or clear mask bits, zeros leave them alone
   assign set_bits = bus.set_wr ? bus.wbits : '0;
   assign clr_bits = bus.clr_wr ? bus.wbits : '0;
   assign mask_d   = (mask_q | set_bits) & ~clr_bits;
   assign rise     = bus.flags & ~prev_q;

   // Mask and edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= MASK_RST;
         prev_q <= '0;
      end else begin
         mask_q <= mask_d;
         prev_q <= bus.flags;
      end
   end

   // Sticky latch per flag; a rising edge beats a clear in the same cycle
   for (genvar i = 0; i < FLAG_N; i++) begin : g_evt
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            evt_q[i] <= 1'h0;
         end else begin
            evt_q[i] <= rise[i] | (evt_q[i] & ~(bus.evt_clr_wr & bus.wbits[i]));
         end
      end
   end

   // Level line: any live flag that is enabled
   assign bus.irq  = |(bus.flags & mask_q);
   assign bus.mask = mask_q;
   assign bus.evt  = evt_q;

endmodule : mcr_irq_unit

// File: src/mcr_top.sv
// Memory copy relay: APB registers, holding register relay and DMA channel window
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module mcr_top #(
   parameter int unsigned ADDR_W = mcr_pkg::OFF_W
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // APB slave
   input  wire logic [ADDR_W-1:0]          paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [mcr_pkg::DATA_W-1:0] pwdata,
   output logic      [mcr_pkg::DATA_W-1:0] prdata,
   output logic                            pready,
   output logic                            pslverr,
   // DMA channel register window
   output logic                            chan_psel,
   output logic                            chan_penable,
   output logic                            chan_pwrite,
   output logic      [mcr_pkg::OFF_W-1:0]  chan_paddr,
   output logic      [mcr_pkg::DATA_W-1:0] chan_pwdata,
   input  wire logic [mcr_pkg::DATA_W-1:0] chan_prdata,
   input  wire logic                       chan_pready,
   input  wire logic                       chan_pslverr,
   // Transmit channel element writes
   input  wire logic                       tx_valid,
   input  wire logic [mcr_pkg::DATA_W-1:0] tx_data,
   output logic                            tx_ready,
   // Receive channel element reads
   output logic                            rx_valid,
   output logic      [mcr_pkg::DATA_W-1:0] rx_data,
   input  wire logic                       rx_ready,
   // Receive channel status
   input  wire logic                       end_of_transfer_flag,
   input  wire logic                       buffer_full_flag,
   // Interrupt
   output logic                            irq
);
   import mcr_pkg::*;

   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   if (ADDR_W < OFF_W) begin : g_bad_addr_w
      $error("ADDR_W must cover the 12-bit register window");
   end

   localparam int unsigned PAD_W  = DATA_W - FLAG_N;
   localparam int unsigned SPAD_W = DATA_W - SIZE_W;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------

   // Exact match of one register word
   function automatic logic off_is(input logic [OFF_W-1:0] off, input logic [OFF_W-1:0] reg_off);
      off_is = (off == reg_off);
   endfunction : off_is

   // Lane mask of one element for a size code; spare code acts as word
   function automatic logic [DATA_W-1:0] lane_mask(input logic [SIZE_W-1:0] size);
      case (size)
         SIZE_BYTE: lane_mask = LANE_BYTE;
         SIZE_HALF: lane_mask = LANE_HALF;
         SIZE_WORD: lane_mask = LANE_WORD;
         default:   lane_mask = LANE_WORD;
      endcase
   endfunction : lane_mask

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic [OFF_W-1:0] off;
   logic             upper_set;
   logic             acc;
   logic             wr_acc;
   logic             hit_hold;
   logic             hit_size;
   logic             hit_ier;
   logic             hit_idr;
   logic             hit_imr;
   logic             hit_isr;
   logic             hit_rsv;
   logic             hit_chan;
   logic             hit_evt;
   logic             hit_evt_clr;
   logic             hit_local;
   logic             unmapped;

   assign off = paddr[OFF_W-1:0];

   // Address bits above the window push the access out of the map
   if (ADDR_W > OFF_W) begin : g_upper
      assign upper_set = |paddr[ADDR_W-1:OFF_W];
   end else begin : g_no_upper
      assign upper_set = 1'h0;
   end

   // Word decode of each register
   assign hit_hold    = ~upper_set & off_is(off, OFF_HOLD);
   assign hit_size    = ~upper_set & off_is(off, OFF_SIZE);
   assign hit_ier     = ~upper_set & off_is(off, OFF_IER);
   assign hit_idr     = ~upper_set & off_is(off, OFF_IDR);
   assign hit_imr     = ~upper_set & off_is(off, OFF_IMR);
   assign hit_isr     = ~upper_set & off_is(off, OFF_ISR);
   assign hit_evt     = ~upper_set & off_is(off, OFF_EVT);
   assign hit_evt_clr = ~upper_set & off_is(off, OFF_EVT_CLR);

   // Reserved gap reads zero; channel range is handed outward
   assign hit_rsv  = ~upper_set & (off >= OFF_RSV_LO) & (off <= OFF_RSV_HI);
   assign hit_chan = ~upper_set & (off >= OFF_CHAN_LO) & (off <= OFF_CHAN_HI);

   assign hit_local = hit_hold | hit_size | hit_ier | hit_idr | hit_imr | hit_isr
                    | hit_evt | hit_evt_clr | hit_rsv;
   assign unmapped  = ~hit_local & ~hit_chan;

   // Access phase; local registers answer with no wait state
   assign acc    = psel & penable;
   assign wr_acc = acc & pwrite & ~hit_chan;

   // ----------------------------------------
   // DMA channel register window
   // ----------------------------------------

   // Pass the transfer straight through while the channel range is addressed
   assign chan_psel    = psel & hit_chan;
   assign chan_penable = penable & hit_chan;
   assign chan_pwrite  = pwrite;
   assign chan_paddr   = off;
   assign chan_pwdata  = pwdata;

   // ----------------------------------------
   // Element size register
   // ----------------------------------------
   logic [SIZE_W-1:0] size_q;
   logic [SIZE_W-1:0] size_d;

   // Only the size field is stored; upper bits read zero
   assign size_d = (wr_acc & hit_size) ? pwdata[SIZE_W-1:0] : size_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         size_q <= SIZE_RST;
      end else begin
         size_q <= size_d;
      end
   end

   // ----------------------------------------
   // Holding register relay
   // ----------------------------------------
   logic [DATA_W-1:0] hold_q;
   logic [DATA_W-1:0] hold_d;
   logic              full_q;
   logic              full_d;
   logic              tx_take;
   logic              rx_take;
   logic              sw_hold_wr;

   // One element at a time: transmit fills, receive drains
   assign tx_take    = tx_valid & ~full_q;
   assign rx_take    = rx_ready & full_q;
   assign sw_hold_wr = wr_acc & hit_hold;

   // Transmit element trimmed to the selected width wins over software
   assign hold_d = tx_take    ? (tx_data & lane_mask(size_q)) :
                   sw_hold_wr ? pwdata :
                                hold_q;

   // Occupancy: set by a transmit element, cleared by the receive read
   assign full_d = tx_take | (full_q & ~rx_take);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= HOLD_RST;
         full_q <= 1'h0;
      end else begin
         hold_q <= hold_d;
         full_q <= full_d;
      end
   end

   // Channel handshakes; the channels keep their counts equal
   assign tx_ready = ~full_q;
   assign rx_valid = full_q;
   assign rx_data  = hold_q;

   // ----------------------------------------
   // Interrupt unit
   // ----------------------------------------
   mcr_irq_if irq_bus ();

   logic [FLAG_N-1:0] live_flags;

   // Live receive channel flags
   assign live_flags[BIT_END]  = end_of_transfer_flag;
   assign live_flags[BIT_FULL] = buffer_full_flag;

   // Register writes steering the mask and event latches
   assign irq_bus.set_wr     = wr_acc & hit_ier;
   assign irq_bus.clr_wr     = wr_acc & hit_idr;
   assign irq_bus.evt_clr_wr = wr_acc & hit_evt_clr;
   assign irq_bus.wbits      = pwdata[FLAG_N-1:0];
   assign irq_bus.flags      = live_flags;

   mcr_irq_unit #(
      .FLAG_N (FLAG_N)
   ) u_irq (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (irq_bus)
   );

   assign irq = irq_bus.irq;

   // ----------------------------------------
   // Read data and answer
   // ----------------------------------------
   logic [DATA_W-1:0] rd_local;

   // Write-only and reserved words read zero
   assign rd_local = hit_hold ? hold_q :
                     hit_size ? {{SPAD_W{1'h0}}, size_q} :
                     hit_imr  ? {{PAD_W{1'h0}}, irq_bus.mask} :
                     hit_isr  ? {{PAD_W{1'h0}}, live_flags} :
                     hit_evt  ? {{PAD_W{1'h0}}, irq_bus.evt} :
                                '0;

   // Channel window waits on the channel; everything else is immediate
   assign prdata  = hit_chan ? chan_prdata : rd_local;
   assign pready  = hit_chan ? chan_pready : 1'h1;
   assign pslverr = hit_chan ? (acc & chan_pslverr) : (acc & unmapped);

endmodule : mcr_top

// File: test/mcr_checker_properties.sv
// Port-level checker for the memory copy relay
`timescale 1ns/1ps
module mcr_checker #(
   parameter int unsigned ADDR_W = mcr_pkg::OFF_W
) (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic [ADDR_W-1:0]          paddr,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [mcr_pkg::DATA_W-1:0] pwdata,
   input wire logic [mcr_pkg::DATA_W-1:0] prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       chan_psel,
   input wire logic                       chan_penable,
   input wire logic                       chan_pwrite,
   input wire logic [mcr_pkg::OFF_W-1:0]  chan_paddr,
   input wire logic [mcr_pkg::DATA_W-1:0] chan_pwdata,
   input wire logic                       tx_valid,
   input wire logic                       tx_ready,
   input wire logic                       rx_valid,
   input wire logic [mcr_pkg::DATA_W-1:0] rx_data,
   input wire logic                       rx_ready,
   input wire logic                       end_of_transfer_flag,
   input wire logic                       buffer_full_flag,
   input wire logic                       irq
);
   import mcr_pkg::*;
   // ----------------------------------------
   // Access qualifiers
   // ----------------------------------------
   wire rd_acc = psel && penable && !pwrite;
   wire wr_acc = psel && penable && pwrite;
   wire in_win = paddr >= OFF_CHAN_LO && paddr <= OFF_CHAN_HI;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   local_ready_a: assert property (psel && penable && paddr < OFF_CHAN_LO |-> pready && !pslverr)
      else $error("local access not answered at once");
   window_sel_a: assert property (chan_psel == (psel && in_win))
      else $error("channel select does not match window");
   window_pass_a: assert property (chan_psel |->
      chan_penable == penable && chan_pwrite == pwrite && chan_paddr == paddr[mcr_pkg::OFF_W-1:0]
      && chan_pwdata == pwdata)
      else $error("channel window does not pass the transfer through");
   reserved_zero_a: assert property (rd_acc && paddr >= OFF_RSV_LO && paddr <= OFF_RSV_HI |->
      prdata == 32'h0)
      else $error("reserved read not zero");
   flags_view_a: assert property (rd_acc && paddr == OFF_ISR |->
      prdata == {30'h0, buffer_full_flag, end_of_transfer_flag})
      else $error("status read differs from live flags");
   irq_cause_a: assert property (irq |-> end_of_transfer_flag || buffer_full_flag)
      else $error("interrupt without flag");
   enable_irq_a: assert property (wr_acc && paddr == OFF_IER && pwdata[0] ##1
      end_of_transfer_flag |-> irq)
      else $error("enabled end flag gives no interrupt");
   disable_irq_a: assert property (wr_acc && paddr == OFF_IDR && pwdata[1:0] == 2'h3 |=> !irq)
      else $error("interrupt stays after full disable");
   relay_take_a: assert property (tx_valid && tx_ready |=> rx_valid && !tx_ready)
      else $error("element not offered after transmit write");
   relay_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("offered element changed before taken");
   relay_give_a: assert property (rx_valid && rx_ready |=> !rx_valid && tx_ready)
      else $error("holding register not freed after read");
endmodule : mcr_checker

bind mcr_top mcr_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .chan_psel(chan_psel), .chan_penable(chan_penable), .chan_pwrite(chan_pwrite), .chan_paddr(chan_paddr),
   .chan_pwdata(chan_pwdata), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
   .rx_ready(rx_ready), .end_of_transfer_flag(end_of_transfer_flag), .buffer_full_flag(buffer_full_flag), .irq(irq));

// File: test/mcr_dma_model.sv
// Behavioural transmit and receive channels with their register block
`timescale 1ns/1ps
module mcr_dma_model (
   input  wire logic        pclk,
   output logic             tx_valid,
   output logic [31:0]      tx_data,
   input  wire logic        tx_ready,
   input  wire logic        rx_valid,
   input  wire logic [31:0] rx_data,
   output logic             rx_ready,
   output logic [1:0]       flg,
   input  wire logic        chan_psel,
   input  wire logic        chan_penable,
   input  wire logic [11:0] chan_paddr,
   output logic [31:0]      chan_prdata,
   output logic             chan_pready,
   output logic             chan_pslverr
);
   logic        wait_q = 1'b0;
   logic        txr_n;
   logic        rxv_n;
   logic [31:0] rxd_n;
   initial begin
      tx_valid = 1'b0;
      tx_data  = 32'h0;
      rx_ready = 1'b0;
      flg      = 2'h0;
   end
   // Mid-cycle copies of what the next rising edge samples
   always @(negedge pclk) begin
      txr_n = tx_ready;
      rxv_n = rx_valid;
      rxd_n = rx_data;
   end
   // Channel registers: one wait state, address echoed, inverted when idle
   always @(posedge pclk) wait_q <= chan_penable && !wait_q;
   assign chan_pready = chan_penable && wait_q;
   // Channel words with address bit 5 set (0x120 and 0x124) answer with an error
   assign chan_pslverr = chan_penable && chan_paddr[5];
   assign chan_prdata = chan_psel ? {20'hC4A00, chan_paddr} : ~{20'hC4A00, chan_paddr};
   // Transmit hands one element in, receive takes it after a stall
   task automatic move(input logic [31:0] d, input int stall, output logic [31:0] got);
      @(posedge pclk);
      tx_valid <= 1'b1;
      tx_data  <= d;
      do @(posedge pclk); while (txr_n !== 1'b1);
      tx_valid <= 1'b0;
      tx_data  <= ~d;
      repeat (stall) @(posedge pclk);
      rx_ready <= 1'b1;
      do @(posedge pclk); while (rxv_n !== 1'b1);
      got = rxd_n;
      rx_ready <= 1'b0;
   endtask : move
   // Receive channel status levels
   task automatic set_flags(input logic [1:0] f);
      @(posedge pclk);
      flg <= f;
   endtask : set_flags
endmodule : mcr_dma_model

// File: test/test_memory_copy_relay.sv
// Self-checking bench: APB registers, element relay, flags and interrupt
`timescale 1ns/1ps
module test_memory_copy_relay;
   import mcr_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, tx_data, rx_data, chan_pwdata, chan_prdata, rd_n, got;
   logic [11:0] chan_paddr;
   logic [1:0]  flg;
   logic        pready, pslverr, chan_psel, chan_penable, chan_pwrite, chan_pready, rdy_n, err_n;
   logic        tx_valid, tx_ready, rx_valid, rx_ready, irq, chan_pslverr;
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          cyc = 0;
   logic [31:0] lane [4] = '{LANE_BYTE, LANE_HALF, LANE_WORD, LANE_WORD};
   logic [31:0] wv [5] = '{32'h1, 32'h2, 32'h0, 32'h1, 32'h0};
   logic [31:0] mv [5] = '{32'h1, 32'h3, 32'h3, 32'h2, 32'h2};

   mcr_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_psel(chan_psel),
      .chan_penable(chan_penable), .chan_pwrite(chan_pwrite), .chan_paddr(chan_paddr), .chan_pwdata(chan_pwdata),
      .chan_prdata(chan_prdata), .chan_pready(chan_pready), .chan_pslverr(chan_pslverr), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .end_of_transfer_flag(flg[0]), .buffer_full_flag(flg[1]), .irq(irq));
   mcr_dma_model dma (.pclk(pclk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .flg(flg), .chan_psel(chan_psel),
      .chan_penable(chan_penable), .chan_paddr(chan_paddr), .chan_prdata(chan_prdata), .chan_pready(chan_pready),
      .chan_pslverr(chan_pslverr));

   // Clock, mid-cycle samples and hang guard
   always #10 pclk = ~pclk;
   always @(negedge pclk) begin
      rdy_n = pready;
      err_n = pslverr;
      rd_n  = prdata;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (rdy_n !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      chk(rd_n, e);
      chk({31'h0, err_n}, {31'h0, ee});
   endtask : rc
   task automatic irq_is(input logic e);
      @(negedge pclk);
      chk({31'h0, irq}, {31'h0, e});
   endtask : irq_is
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rc(OFF_HOLD, HOLD_RST, 1'b0);
      rc(OFF_SIZE, 32'h0000_0002, 1'b0);
      rc(OFF_IMR, 32'h0000_0000, 1'b0);
      rc(OFF_ISR, 32'h0, 1'b0);
      $display("test reset values done");
      apb(1'b1, OFF_HOLD, 32'hA5C3_1E0F);
      rc(OFF_HOLD, 32'hA5C3_1E0F, 1'b0);
      apb(1'b1, OFF_ISR, 32'h3);
      rc(OFF_ISR, 32'h0, 1'b0);
      apb(1'b1, OFF_RSV_LO, 32'hFFFF_FFFF);
      rc(OFF_RSV_LO, 32'h0, 1'b0);
      rc(OFF_RSV_HI, 32'h0, 1'b0);
      rc(OFF_CHAN_LO, {20'hC4A00, OFF_CHAN_LO}, 1'b0);
      rc(OFF_CHAN_HI, {20'hC4A00, OFF_CHAN_HI}, 1'b1);
      rc(12'h200, 32'h0, 1'b1);
      $display("test register map done");
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, OFF_SIZE, 32'(k));
         rc(OFF_SIZE, 32'(k), 1'b0);
         dma.move(32'hDEAD_BEEF, 2 * k, got);
         chk(got, 32'hDEAD_BEEF & lane[k]);
         dma.move(32'h1234_5678, 0, got);
         chk(got, 32'h1234_5678 & lane[k]);
         rc(OFF_HOLD, 32'h1234_5678 & lane[k], 1'b0);
      end
      $display("test relay sizes done");
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, i < 3 ? OFF_IER : OFF_IDR, wv[i]);
         rc(OFF_IMR, mv[i], 1'b0);
      end
      dma.set_flags(2'b01);
      rc(OFF_ISR, 32'h1, 1'b0);
      irq_is(1'b0);
      dma.set_flags(2'b11);
      rc(OFF_ISR, 32'h3, 1'b0);
      irq_is(1'b1);
      apb(1'b1, OFF_IDR, 32'h2);
      irq_is(1'b0);
      apb(1'b1, OFF_IER, 32'h1);
      irq_is(1'b1);
      apb(1'b1, OFF_IDR, 32'h3);
      irq_is(1'b0);
      rc(OFF_EVT, 32'h3, 1'b0);
      apb(1'b1, OFF_EVT_CLR, 32'h1);
      rc(OFF_EVT, 32'h2, 1'b0);
      dma.set_flags(2'b00);
      $display("test interrupts done");
      wrap_up;
   end
endmodule : test_memory_copy_relay
